// ### verilog/iwr_pkg.sv
// Purpose: shared constants and types for the interrupt, wake and reset controller
// Assumes: 10 MHz ref_clk, synchronous active-high reset
// Notes:   register bit positions follow the status/mask layout
package iwr_pkg;
    // interrupt vector
    localparam logic [12:0] VECTOR_ADDR   = 13'h0001;
    localparam logic [12:0] RESET_ADDR    = 13'h0000;
    // status / mask bit positions
    localparam int BIT_TIMER   = 0;
    localparam int BIT_SETUP   = 1;
    localparam int BIT_SUSP    = 2;
    localparam int BIT_USBRST  = 3;
    localparam int BIT_PORT7   = 4;
    localparam int BIT_RESUME  = 7;
    localparam logic [7:0] SRC_MASK        = 8'h9F;
    // special function control bits
    localparam int SFC_RUN      = 4;
    localparam int SFC_DEVRES   = 3;
    localparam int SFC_DUALN    = 7;
    // reset values
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] MASK_RST   = 8'h00;
    localparam logic [7:0] SFC_RST    = 8'hD7;
    localparam logic [7:0] OPM_RST    = 8'hE0;
    // slow clock: ref_clk cycles between slow ticks for each dual-clock rate
    localparam int REF_HZ       = 10_000_000;
    localparam int SLOW_HZ0     = 500;
    localparam int SLOW_HZ1     = 4_000;
    localparam int SLOW_HZ2     = 32_000;
    localparam int SLOW_HZ3     = 256_000;
    localparam int SLOW_DIV0    = REF_HZ / SLOW_HZ0;
    localparam int SLOW_DIV1    = REF_HZ / SLOW_HZ1;
    localparam int SLOW_DIV2    = REF_HZ / SLOW_HZ2;
    localparam int SLOW_DIV3    = REF_HZ / SLOW_HZ3;
    // event carrier from the timer and usb engine
    typedef struct packed {
        logic timer_ovf;
        logic setup_ok;
        logic suspend;
        logic usb_reset;
        logic resume_host;
    } iwr_events_t;
    // core control carrier
    typedef struct packed {
        logic boundary;
        logic global_irq_enable_instr;
        logic global_irq_disable_instr;
        logic return_from_irq_instr;
    } iwr_core_t;
endpackage : iwr_pkg

// ### verilog/iwr_sync3.sv
// Purpose: three-flop synchroniser with agreement filter for pin inputs
// Assumes: one clock domain, synchronous reset
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module iwr_sync3 #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    // pin side
    input  wire logic [W-1:0] pin_in,
    // filtered level
    output logic      [W-1:0] level
);
    logic [W-1:0] s1, s2, s3;       // pipeline stages
    logic [W-1:0] next_level;       // filtered next value

    // accept a change only when stages two and three agree
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_comb begin
                next_level[g] = (s2[g] == s3[g]) ? s3[g] : level[g];
            end
        end
    endgenerate

    // register stages
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s1    <= '0;
            s2    <= '0;
            s3    <= '0;
            level <= '0;
        end else begin
            s1    <= pin_in;
            s2    <= s1;
            s3    <= s2;
            level <= next_level;
        end
    end
endmodule : iwr_sync3

// ### verilog/iwr_ctrl.sv
// Purpose: interrupt latching, dispatch, power-down, dual clock and reset control
// Assumes: core signals instruction boundary and enable/disable/return decodes
// Notes:   registers written by core over plain write strobes and data
//
// Notes on behaviour
// [RULE1] taken interrupt loads pc with vector 0x0001
// [RULE2] timer overflow sets status bit 0
// [RULE3] port 7 change sets status bit 4
// [RULE4] accepted setup transaction sets status bit 1
// [RULE5] usb suspend sets status bit 2
// [RULE6] usb reset sets bit 3, requests interrupt
// [RULE7] unsolicited suspend exit sets status bit 7
// [RULE8] masked source never vectors, flag still sets
// [RULE9] flags sticky until firmware clears them
// [RULE10] firmware clears flags before leaving handler
// [RULE11] enable/return open gate, disable closes it
// [RULE12] clearing run bit enters power down
// [RULE13] wake on resume, watchdog, or port change
// [RULE14] firmware sets port input before sleeping
// [RULE15] clearing bit 7 selects slow oscillator
// [RULE16] host resume interrupt only in dual clock
// [RULE17] power-on clears pc, timer, watchdog, registers
// [RULE18] watchdog restarts program, usb state kept
// [RULE19] usb engine ignores traffic until bus reset
// [RULE20] two bits pick slow clock rate
// [RULE21] mask bit one enables its source
// [RULE22] run bit set by wake falling edge
// [RULE23] request when flag, mask and gate set
// [RULE24] taking interrupt pushes return, closes gate
`timescale 1ns/1ps
module iwr_ctrl (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 sys_rst,       // power-on reset
    input  wire logic                 wdt_ovf,       // watchdog overflow pulse
    // core handshake
    input  wire iwr_pkg::iwr_core_t   core,
    input  wire logic [12:0]          pc_now,        // address of next instruction
    // register writes from core
    input  wire logic                 wr_status,
    input  wire logic                 wr_mask,
    input  wire logic                 wr_sfc,
    input  wire logic                 wr_opm,
    input  wire logic [7:0]           wr_data,
    // event sources
    input  wire iwr_pkg::iwr_events_t ev,
    input  wire logic [7:0]           port7_pin,     // asynchronous pins
    input  wire logic                 wake_n,        // wake-up signal, active low
    // register contents
    output logic      [7:0]           interrupt_status_reg,
    output logic      [7:0]           interrupt_mask_reg,
    output logic      [7:0]           special_function_control,
    output logic      [7:0]           operation_mode_control,
    // core control outputs
    output logic                      irq_take,      // vector this boundary
    output logic      [12:0]          pc_load,
    output logic                      pc_load_en,
    output logic                      stack_push,
    output logic      [12:0]          stack_data,
    output logic                      gate_open,
    // clocking and reset outputs
    output logic                      osc_run,       // main oscillator enabled
    output logic                      slow_sel,      // slow clock selected
    output logic                      slow_tick,     // slow clock enable pulse
    output logic                      timer_clr,
    output logic                      wdt_clr,
    output logic                      usb_active     // engine answers traffic
);
    // power/run state
    typedef enum logic [1:0] {
        ST_RUN   = 2'b01,
        ST_SLEEP = 2'b10
    } iwr_pwr_t;

    iwr_pwr_t    pwr, next_pwr;              // power state
    logic [7:0]  next_status;                // status next value
    logic [7:0]  next_mask;
    logic [7:0]  next_sfc;
    logic [7:0]  next_opm;
    logic        next_gate;
    logic        next_usb_active;
    logic [7:0]  p7_level;                   // filtered port 7
    logic [7:0]  p7_prev;                    // last filtered value
    logic        wake_level;                 // filtered wake
    logic        wake_prev;
    logic        wake_fall;
    logic        susp_prev;                  // suspend last cycle
    logic        p7_change;
    logic [7:0]  set_bits;                   // event bits this cycle
    logic        pending;
    logic [31:0] slow_cnt, next_slow_cnt;
    logic [31:0] slow_lim;
    logic        next_slow_tick;
    logic [12:0] next_pc_load;
    logic        next_pc_load_en;

    // pin synchronisers
    iwr_sync3 #(.W(8)) u_p7 (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pin_in  (port7_pin),
        .level   (p7_level)
    );
    iwr_sync3 #(.W(1)) u_wake (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pin_in  (wake_n),
        .level   (wake_level)
    );

    // edge detection on filtered levels
    always_comb begin
        p7_change = (p7_level != p7_prev);                                    // RULE3
        wake_fall = wake_prev & ~wake_level;
    end

    // event vector in status layout
    always_comb begin
        set_bits = 8'h00;
        set_bits[iwr_pkg::BIT_TIMER]  = ev.timer_ovf;                         // RULE2
        set_bits[iwr_pkg::BIT_PORT7]  = p7_change;                            // RULE3
        set_bits[iwr_pkg::BIT_SETUP]  = ev.setup_ok & usb_active;             // RULE4 RULE19
        set_bits[iwr_pkg::BIT_SUSP]   = ev.suspend & ~susp_prev;              // RULE5
        set_bits[iwr_pkg::BIT_USBRST] = ev.usb_reset;                         // RULE6
        // suspend ends without our own resume signalling
        set_bits[iwr_pkg::BIT_RESUME] = susp_prev & ~ev.suspend
            & ~special_function_control[iwr_pkg::SFC_DEVRES];                 // RULE7
    end

    // request: flag and mask and gate; resume only counts in dual clock
    always_comb begin
        logic [7:0] eff_mask;
        eff_mask = interrupt_mask_reg & iwr_pkg::SRC_MASK;                    // RULE21
        if (~slow_sel) begin
            eff_mask[iwr_pkg::BIT_RESUME] = 1'b0;                            // RULE16
        end
        pending  = |(interrupt_status_reg & eff_mask);                        // RULE8
        irq_take = pending & gate_open & core.boundary & (pwr == ST_RUN);     // RULE23
    end

    // register next values; hardware set wins over firmware clear
    always_comb begin
        next_status = interrupt_status_reg;
        next_mask   = interrupt_mask_reg;
        next_sfc    = special_function_control;
        next_opm    = operation_mode_control;
        if (wr_status) begin
            next_status = wr_data & iwr_pkg::SRC_MASK;                        // RULE9
        end
        next_status = next_status | set_bits;                                 // RULE9
        if (wr_mask) begin
            next_mask = wr_data & iwr_pkg::SRC_MASK;                          // RULE21
        end
        if (wr_opm) begin
            next_opm = wr_data;
        end
        if (wr_sfc) begin
            next_sfc = wr_data;                                               // RULE12 RULE15
        end
        // device resume ends once suspend drops
        if (susp_prev & ~ev.suspend) begin
            next_sfc[iwr_pkg::SFC_DEVRES] = 1'b0;
        end
        // wake sets run again
        if (pwr == ST_SLEEP && (wake_fall || ev.resume_host || p7_change)) begin
            next_sfc[iwr_pkg::SFC_RUN] = 1'b1;                                // RULE13 RULE22
        end
        if (wdt_ovf) begin
            next_sfc[iwr_pkg::SFC_RUN] = 1'b1;                                // RULE13
        end
    end

    // global gate
    always_comb begin
        next_gate = gate_open;
        if (core.global_irq_enable_instr || core.return_from_irq_instr) begin
            next_gate = 1'b1;                                                 // RULE11
        end
        if (core.global_irq_disable_instr) begin
            next_gate = 1'b0;                                                 // RULE11
        end
        if (irq_take) begin
            next_gate = 1'b0;                                                 // RULE24
        end
    end

    // power state follows run bit
    always_comb begin
        case (pwr)
            ST_RUN:   next_pwr = next_sfc[iwr_pkg::SFC_RUN] ? ST_RUN : ST_SLEEP; // RULE12
            ST_SLEEP: next_pwr = next_sfc[iwr_pkg::SFC_RUN] ? ST_RUN : ST_SLEEP;
            default:  next_pwr = ST_RUN;
        endcase
        osc_run  = (pwr == ST_RUN) & special_function_control[iwr_pkg::SFC_DUALN]; // RULE12 RULE15
        slow_sel = ~special_function_control[iwr_pkg::SFC_DUALN];             // RULE15
    end

    // slow clock divider, rate from two mode bits
    always_comb begin
        case (operation_mode_control[7:6])                                    // RULE20
            2'b00:   slow_lim = 32'(iwr_pkg::SLOW_DIV0);
            2'b01:   slow_lim = 32'(iwr_pkg::SLOW_DIV1);
            2'b10:   slow_lim = 32'(iwr_pkg::SLOW_DIV2);
            default: slow_lim = 32'(iwr_pkg::SLOW_DIV3);
        endcase
        next_slow_tick = 1'b0;
        next_slow_cnt  = slow_cnt + 32'd1;
        if (~slow_sel || pwr != ST_RUN) begin
            next_slow_cnt = 32'd0;
        end else if (slow_cnt >= slow_lim - 32'd1) begin
            next_slow_cnt  = 32'd0;
            next_slow_tick = 1'b1;                                            // RULE20
        end
    end

    // program counter redirect and stack push
    always_comb begin
        next_pc_load    = pc_load;
        next_pc_load_en = 1'b0;
        if (wdt_ovf) begin
            next_pc_load    = iwr_pkg::RESET_ADDR;                            // RULE18
            next_pc_load_en = 1'b1;
        end else if (irq_take) begin
            next_pc_load    = iwr_pkg::VECTOR_ADDR;                           // RULE1
            next_pc_load_en = 1'b1;
        end
        stack_push = irq_take;                                                // RULE24
        stack_data = pc_now;
        timer_clr  = sys_rst;                                                 // RULE17
        wdt_clr    = sys_rst | wdt_ovf;                                       // RULE17
    end

    // usb engine wakes to traffic only after a bus reset
    always_comb begin
        next_usb_active = usb_active | ev.usb_reset;                          // RULE19
    end

    // usb state: power-on only, watchdog leaves it alone
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            usb_active <= 1'b0;                                               // RULE17
        end else begin
            usb_active <= next_usb_active;                                    // RULE18
        end
    end

    // core-side state; watchdog reinitialises gate and mask register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            interrupt_status_reg     <= iwr_pkg::STATUS_RST;                  // RULE17
            interrupt_mask_reg       <= iwr_pkg::MASK_RST;
            special_function_control <= iwr_pkg::SFC_RST;
            operation_mode_control   <= iwr_pkg::OPM_RST;
            gate_open                <= 1'b0;
            pwr                      <= ST_RUN;
            pc_load                  <= iwr_pkg::RESET_ADDR;
            pc_load_en               <= 1'b1;
            slow_cnt                 <= 32'd0;
            slow_tick                <= 1'b0;
            p7_prev                  <= 8'h00;
            wake_prev                <= 1'b0;
            susp_prev                <= 1'b0;
        end else begin
            interrupt_status_reg     <= next_status;
            interrupt_mask_reg       <= wdt_ovf ? iwr_pkg::MASK_RST : next_mask; // RULE18
            special_function_control <= next_sfc;
            operation_mode_control   <= next_opm;
            gate_open                <= wdt_ovf ? 1'b0 : next_gate;
            pwr                      <= next_pwr;
            pc_load                  <= next_pc_load;
            pc_load_en               <= next_pc_load_en;
            slow_cnt                 <= next_slow_cnt;
            slow_tick                <= next_slow_tick;
            p7_prev                  <= p7_level;
            wake_prev                <= wake_level;
            susp_prev                <= ev.suspend;
        end
    end

    // checks
    a_vector_load: assert property (@(posedge ref_clk) disable iff (sys_rst)
        irq_take && !wdt_ovf |=> pc_load_en && pc_load == iwr_pkg::VECTOR_ADDR) // RULE1
        else $error("vector not loaded");
    a_timer_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ev.timer_ovf |=> interrupt_status_reg[0])                             // RULE2
        else $error("timer flag missing");
    a_usbrst_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ev.usb_reset |=> interrupt_status_reg[3] && usb_active)               // RULE6
        else $error("usb reset flag missing");
    a_setup_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ev.setup_ok && usb_active |=> interrupt_status_reg[1])                // RULE4
        else $error("setup flag missing");
    a_mask_blocks: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (interrupt_status_reg & interrupt_mask_reg) == 8'h00 |-> !irq_take)   // RULE8
        else $error("masked source taken");
    a_flag_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst)
        interrupt_status_reg[0] && !wr_status |=> interrupt_status_reg[0])    // RULE9
        else $error("flag dropped");
    a_gate_disable: assert property (@(posedge ref_clk) disable iff (sys_rst)
        core.global_irq_disable_instr |=> !gate_open)                                             // RULE11
        else $error("gate still open");
    a_gate_take: assert property (@(posedge ref_clk) disable iff (sys_rst)
        irq_take |-> stack_push ##1 !gate_open)                               // RULE24
        else $error("take did not close gate");
    a_sleep_entry: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !special_function_control[4] && !wdt_ovf |=> pwr == ST_SLEEP || special_function_control[4]) // RULE12
        else $error("no sleep");
    a_resume_dual: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !slow_sel && interrupt_status_reg == 8'h80 |-> !irq_take)             // RULE16
        else $error("resume irq in normal clock");
    a_usb_ignore: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !usb_active && !ev.usb_reset |=> !usb_active)                         // RULE19
        else $error("usb active without reset");
    c_take: cover property (@(posedge ref_clk) irq_take);
    c_sleep_wake: cover property (@(posedge ref_clk) pwr == ST_SLEEP ##1 pwr == ST_RUN);
    c_slow_tick: cover property (@(posedge ref_clk) slow_tick);
endmodule : iwr_ctrl

// ### bench/iwr_core_model.sv
// Purpose: behavioural processor core facing the controller's core side
// Assumes: two ref_clk cycles per instruction, boundary on every other cycle
// Notes:   decodes are issued only on a boundary cycle, never between
`timescale 1ns/1ps
module iwr_core_model (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          sys_rst,
    // firmware requests: eni, global_irq_disable_instr, return_from_irq_instr
    input  wire logic [2:0]    instr_req,
    // controller answers
    input  wire logic          pc_load_en,
    input  wire logic [12:0]   pc_load,
    // core side of the controller
    output iwr_pkg::iwr_core_t core,
    output logic      [12:0]   pc_now
);
    logic phase;   // high on the boundary cycle
    // sequencer: a load beats the sequential fetch
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            phase  <= 1'b0;
            pc_now <= 13'h0000;
        end else begin
            phase <= ~phase;
            if (pc_load_en) begin
                pc_now <= pc_load;
            end else if (phase) begin
                pc_now <= pc_now + 13'h0001;
            end
        end
    end
    // decodes ride on the boundary only, so one request makes one pulse
    assign core = {phase, {3{phase}} & instr_req};
endmodule : iwr_core_model

// ### bench/mcu_interrupt_wake_reset_tb_top.sv
// Purpose: self-checking bench for the interrupt, wake and reset controller
// Assumes: 10 MHz ref_clk, inputs driven 1 ns after the rising edge
// Notes:   slow tick spacing is measured for all four rates, so the run is long
`timescale 1ns/1ps
module mcu_interrupt_wake_reset_tb_top;
    logic                 ref_clk;
    logic                 sys_rst;
    logic                 wdt_ovf;
    logic [2:0]           instr_req;   // eni, global_irq_disable_instr, return_from_irq_instr
    logic                 wr_status, wr_mask, wr_sfc, wr_opm;
    logic [7:0]           wr_data;
    iwr_pkg::iwr_events_t ev;
    logic [7:0]           port7_pin;
    logic                 wake_n;
    iwr_pkg::iwr_core_t   core;
    logic [12:0]          pc_now, pc_load, stack_data, last_pc;
    logic [7:0]           st, mk, sfc, opm;
    logic                 irq_take, pc_load_en, stack_push, gate_open;
    logic                 osc_run, slow_sel, slow_tick, timer_clr, wdt_clr, usb_active;
    int                   bad_count, checks, c0, n, b;
    int                   irq_cnt = 0;   // taken interrupts seen so far
    int                   push_cnt = 0;  // stack pushes seen so far
    logic [1:0]           rst_clr, wdt_clrs;   // clear outputs seen in reset and watchdog
    int                   order[5] = '{3, 0, 1, 2, 4};   // bus reset first
    int                   divs[4] = '{iwr_pkg::SLOW_DIV0, iwr_pkg::SLOW_DIV1,
                                      iwr_pkg::SLOW_DIV2, iwr_pkg::SLOW_DIV3};

    iwr_ctrl DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .wdt_ovf(wdt_ovf), .core(core),
        .pc_now(pc_now), .wr_status(wr_status), .wr_mask(wr_mask), .wr_sfc(wr_sfc),
        .wr_opm(wr_opm), .wr_data(wr_data), .ev(ev), .port7_pin(port7_pin), .wake_n(wake_n),
        .interrupt_status_reg(st), .interrupt_mask_reg(mk), .special_function_control(sfc),
        .operation_mode_control(opm), .irq_take(irq_take), .pc_load(pc_load),
        .pc_load_en(pc_load_en), .stack_push(stack_push), .stack_data(stack_data),
        .gate_open(gate_open), .osc_run(osc_run), .slow_sel(slow_sel), .slow_tick(slow_tick),
        .timer_clr(timer_clr), .wdt_clr(wdt_clr), .usb_active(usb_active));
    iwr_core_model CORE (.ref_clk(ref_clk), .sys_rst(sys_rst), .instr_req(instr_req),
        .pc_load_en(pc_load_en), .pc_load(pc_load), .core(core), .pc_now(pc_now));

    // 100 ns clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // reference of taken interrupts and the last loaded address
    always @(posedge ref_clk) begin
        if (irq_take === 1'b1) irq_cnt <= irq_cnt + 1;
        if (stack_push === 1'b1) push_cnt <= push_cnt + 1;
        if (pc_load_en === 1'b1) last_pc <= pc_load;
        if (sys_rst === 1'b1) rst_clr <= {timer_clr, wdt_clr};
        if (wdt_ovf === 1'b1) wdt_clrs <= {timer_clr, wdt_clr};
    end
    // watchdog: the slow tick sweep needs about 46k cycles, so 90k means a hang
    initial begin
        repeat (90_000) @(posedge ref_clk);
        bad_count++;
        final_report();
    end

    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    // sel 0 status, 1 mask, 2 special function, 3 mode; strobe then idle cycle
    task automatic wr(input int sel, input logic [7:0] d);
        wr_data = d;
        {wr_status, wr_mask, wr_sfc, wr_opm} = 4'h8 >> sel;
        tick(1);
        {wr_status, wr_mask, wr_sfc, wr_opm} = 4'h0;
        tick(1);
    endtask : wr
    task automatic instr(input logic [2:0] v);
        instr_req = v;
        tick(2);
        instr_req = 3'b000;
        tick(1);
    endtask : instr
    // one event of source s; 4 is a port change, 5 a host resume
    task automatic fire(input int s);
        case (s)
            0: ev.timer_ovf = 1'b1;
            1: ev.setup_ok = 1'b1;
            2: ev.suspend = 1'b1;
            3: ev.usb_reset = 1'b1;
            5: begin
                ev.suspend = 1'b1;   // host resume ends a suspended bus
                tick(1);
                ev.suspend = 1'b0;
                ev.resume_host = 1'b1;
            end
            default: port7_pin = port7_pin ^ 8'($urandom_range(1, 255));
        endcase
        tick(1);
        ev = '0;
        tick(7);   // covers the pin synchroniser
    endtask : fire
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    initial begin
        {sys_rst, wdt_ovf, wr_status, wr_mask, wr_sfc, wr_opm} = 6'b100000;
        instr_req = 3'b000;
        wr_data = 8'h00;
        ev = '0;
        port7_pin = 8'h00;
        wake_n = 1'b1;
        bad_count = 0;
        checks = 0;
        void'($urandom(80));
        tick(4);
        sys_rst = 1'b0;
        tick(2);
        chk(16'({st, mk}), 16'h0000);
        chk(16'({sfc, opm}), {iwr_pkg::SFC_RST, iwr_pkg::OPM_RST});
        chk(16'({gate_open, last_pc}), 16'(iwr_pkg::RESET_ADDR));
        chk(16'(rst_clr), 16'h0003);
        wr(1, 8'hFF);
        chk(16'(mk), 16'(iwr_pkg::SRC_MASK));
        fire(1);
        chk(16'({usb_active, st[1]}), 16'h0000);
        instr(3'b100);
        chk(16'(gate_open), 16'h0001);
        // each source but host resume masked, then unmasked
        foreach (order[k]) begin
            b = order[k];
            wr(1, 8'h00);
            c0 = irq_cnt;
            fire(b);
            chk(16'(st[b]), 16'h0001);
            chk(16'(irq_cnt - c0), 16'h0000);
            wr(0, 8'h00);
            chk(16'(st), 16'h0000);
            wr(1, 8'h01 << b);
            fire(b);
            chk(16'(irq_cnt - c0), 16'h0001);
            chk(16'(last_pc), 16'(iwr_pkg::VECTOR_ADDR));
            chk(16'(push_cnt), 16'(irq_cnt));
            chk(16'(gate_open), 16'h0000);
            wr(0, 8'h00);
            instr(3'b001);
            chk(16'(gate_open), 16'h0001);
        end
        chk(16'(usb_active), 16'h0001);
        // closed gate holds back an enabled source
        instr(3'b010);
        chk(16'(gate_open), 16'h0000);
        wr(1, 8'h01);
        c0 = irq_cnt;
        fire(0);
        chk(16'(irq_cnt - c0), 16'h0000);
        wr(0, 8'h00);
        // host resume: flag in normal mode, interrupt only in dual clock
        wr(1, 8'h80);
        instr(3'b100);
        fire(5);
        chk(16'({st[7], 8'(irq_cnt - c0)}), 16'h0100);
        wr(0, 8'h00);
        wr(2, 8'h57);
        chk(16'({slow_sel, osc_run}), 16'h0002);
        fire(5);
        chk(16'(irq_cnt - c0), 16'h0001);
        wr(0, 8'h00);
        instr(3'b001);
        // slow tick spacing for every rate code
        for (int r = 0; r < 4; r++) begin
            wr(3, {r[1:0], 6'h20});
            n = 0;
            while (slow_tick !== 1'b1 && n < 30000) begin
                tick(1);
                n++;
            end
            tick(1);
            n = 1;
            while (slow_tick !== 1'b1 && n < 30000) begin
                tick(1);
                n++;
            end
            chk(16'(n), 16'(divs[r]));
        end
        wr(2, iwr_pkg::SFC_RST);
        // power down, woken by wake line, host resume and port change
        wr(1, 8'h00);
        for (int w = 0; w < 3; w++) begin
            wr(2, 8'hC7);
            chk(16'({osc_run, sfc[iwr_pkg::SFC_RUN]}), 16'h0000);
            if (w == 0) wake_n = 1'b0;
            else fire(w == 1 ? 5 : 4);
            n = 0;
            while (sfc[iwr_pkg::SFC_RUN] !== 1'b1 && n < 20) begin
                tick(1);
                n++;
            end
            chk(16'(sfc[iwr_pkg::SFC_RUN]), 16'h0001);
            wake_n = 1'b1;
            tick(1);
        end
        // watchdog restart keeps the usb engine
        wr(0, 8'h00);
        wr(1, 8'h9F);
        wdt_ovf = 1'b1;
        tick(1);
        wdt_ovf = 1'b0;
        tick(3);
        chk(16'(last_pc), 16'(iwr_pkg::RESET_ADDR));
        chk(16'(wdt_clrs), 16'h0001);
        chk(16'({usb_active, mk}), 16'h0100);
        final_report();
    end
endmodule : mcu_interrupt_wake_reset_tb_top
